// File: verilog/slave_ctrl_error_regs_defines.svh
// register offsets, field positions, reset values and masks of the control and error register group
`ifndef SLAVE_CTRL_ERROR_REGS_DEFINES_SVH
`define SLAVE_CTRL_ERROR_REGS_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_SLAVE_PORT_CONTROL 6'h04
`define OFS_ERROR_FLAGS 6'h08
`define OFS_ERROR_FLAG_ENABLES 6'h0c
`define OFS_MASTER_FAULT_IRQ_ENABLE 6'h10
`define OFS_BUILD_CONFIGURATION 6'h14

// ****************************************
// slave_port_control fields
// ****************************************
`define BIT_BLOCK_READS_WHILE_WRITES_PENDING 19
`define BIT_EXCLUSIVE_ACCESS_OFF 18
`define BIT_IN_ORDER_WRITE_RESPONSES 17
`define BIT_IN_ORDER_READ_RESPONSES 16
`define BIT_SLAVE_FAULT_OUTPUT_ENABLE 15
`define MASK_SLAVE_PORT_CONTROL 32'h000f_8000
`define RST_SLAVE_PORT_CONTROL 32'h0000_0000

// ****************************************
// error_flags and error_flag_enables fields
// ****************************************
`define BIT_MASTER_COMPLETION_FLAG 31
`define BIT_MASTER_READ_ID_FAULT 20
`define BIT_MASTER_WRITE_ID_FAULT 19
`define BIT_MASTER_WRITE_RESP_FAULT 18
`define BIT_MASTER_READ_RESP_FAULT 17
`define BIT_MASTER_READ_LENGTH_FAULT 16
`define BIT_SLAVE_STROBE_LANE_FAULT 1
`define BIT_SLAVE_WRITE_LENGTH_FAULT 0
`define MASK_ERROR_FLAGS 32'h801f_0003
`define MASK_SLAVE_FAULTS 32'h0000_ffff
`define MASK_MASTER_FAULTS 32'h7fff_0000
`define RST_ERROR_FLAGS 32'h0000_0000
`define RST_ERROR_FLAG_ENABLES 32'h8000_0000

// ****************************************
// master_fault_irq_enable fields
// ****************************************
`define BIT_MASTER_FAULT_OUTPUT_ENABLE 15
`define MASK_MASTER_FAULT_IRQ_ENABLE 32'h0000_8000
`define RST_MASTER_FAULT_IRQ_ENABLE 32'h0000_0000

// ****************************************
// build_configuration fields
// ****************************************
`define POS_MASTER_DATA_WIDTH_CODE 28
`define POS_SLAVE_DATA_WIDTH_CODE 25
`define BIT_ADVANCED_MODE_FLAG 24
`define BIT_BASIC_MODE_FLAG 23

// ****************************************
// bus responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/slave_ctrl_error_regs_pkg.sv
// types shared by the control and error register group
package slave_ctrl_error_regs_pkg;

   typedef logic [31:0] word_t;
   typedef logic [1:0] resp_t;
   typedef logic [2:0] width_code_t;

   typedef struct packed {
      word_t slave_port_control;
      word_t error_flags;
      word_t error_flag_enables;
      word_t master_fault_irq_enable;
      logic both_done_seen;
      logic aw_ready;
      logic w_ready;
      logic b_valid;
      resp_t b_resp;
      logic ar_ready;
      logic r_valid;
      word_t r_data;
      resp_t r_resp;
      logic fault_out;
      logic completion_irq;
   } regs_state_t;

endpackage

// File: verilog/slave_ctrl_error_regs.sv
// control, error status and build configuration registers behind the register-access slave port
//
// Behaviour
// - bit 19 set: slave logic holds reads while writes pend, one read per write.
// - bit 18 set: slave port drops exclusive access and read error responses.
// - bit 17 set: slave write responses leave in request order.
// - bit 16 set: slave reads complete strictly in arrival order.
// - slave-control bit 15 set: fault output high while any flag 15:0 set.
// - flag 31 set when both command engines finish, if enabled; raises interrupt.
// - flag 20 set on master read beat with unknown ID.
// - flag 19 set on master write response with unknown ID.
// - flag 18 set on master write response not allowed by expected response.
// - flag 17 set on master read response not allowed by expected response.
// - flag 16 set on misplaced or missing last marker on master reads.
// - flag 1 set on slave write strobe in an illegal byte lane.
// - flag 0 set on misplaced or missing last marker on slave writes.
// - flags clear by writing one; zero bits leave flags untouched.
// - disabled error sets no flag and signals nothing.
// - each enable bit gates the flag at the same position.
// - completion interrupt enable bit 31 resets to one.
// - fault enable bit 15 set: fault output high while any flag 30:16 set.
// - build configuration read-only: master width, slave width, advanced and basic flags.
`timescale 1ns/10ps
`include "slave_ctrl_error_regs_defines.svh"

module slave_ctrl_error_regs #(
   parameter int ADDR_W = 6,
   parameter logic [2:0] MASTER_WIDTH_CODE = 3'h0,
   parameter logic [2:0] SLAVE_WIDTH_CODE = 3'h0,
   parameter logic ADVANCED_MODE = 1'b1
) (
   input wire logic core_clk, // core clock, 100 MHz
   input wire logic nrst, // asynchronous reset, active low
   // register-access slave port
   input wire logic [ADDR_W-1:0] s_awaddr, // write address
   input wire logic s_awvalid, // write address valid
   output logic s_awready, // write address ready
   input wire slave_ctrl_error_regs_pkg::word_t s_wdata, // write data
   input wire logic [3:0] s_wstrb, // write byte enables
   input wire logic s_wvalid, // write data valid
   output logic s_wready, // write data ready
   output slave_ctrl_error_regs_pkg::resp_t s_bresp, // write response
   output logic s_bvalid, // write response valid
   input wire logic s_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_araddr, // read address
   input wire logic s_arvalid, // read address valid
   output logic s_arready, // read address ready
   output slave_ctrl_error_regs_pkg::word_t s_rdata, // read data
   output slave_ctrl_error_regs_pkg::resp_t s_rresp, // read response
   output logic s_rvalid, // read data valid
   input wire logic s_rready, // read data ready
   // events from the traffic logic, one-cycle pulses except the two done inputs, which are levels
   input wire logic master_write_cmds_done, // write command engine finished, level
   input wire logic master_read_cmds_done, // read command engine finished, level
   input wire logic master_read_id_fault, // read beat with unmatched id
   input wire logic master_write_id_fault, // write response with unmatched id
   input wire logic master_write_resp_fault, // write response code not expected
   input wire logic master_read_resp_fault, // read response code not expected
   input wire logic master_read_length_fault, // read last marker misplaced
   input wire logic slave_strobe_lane_fault, // slave strobe in illegal lane
   input wire logic slave_write_length_fault, // slave write last marker misplaced
   // controls to the slave port logic
   output logic block_reads_while_writes_pending, // hold reads behind writes
   output logic exclusive_access_off, // no exclusive access, no read errors
   output logic in_order_write_responses, // write responses in request order
   output logic in_order_read_responses, // reads completed in arrival order
   // system outputs
   output logic err_out, // error output, level
   output logic irq_out // completion interrupt, level
);
   import slave_ctrl_error_regs_pkg::*;

   regs_state_t cur;
   regs_state_t nxt;

   // ****************************************
   // constant build information
   // ****************************************
   word_t build_word;
   assign build_word = ({29'h0, MASTER_WIDTH_CODE} << `POS_MASTER_DATA_WIDTH_CODE)
      | ({29'h0, SLAVE_WIDTH_CODE} << `POS_SLAVE_DATA_WIDTH_CODE)
      | ({31'h0, ADVANCED_MODE} << `BIT_ADVANCED_MODE_FLAG)
      | ({31'h0, ~ADVANCED_MODE} << `BIT_BASIC_MODE_FLAG);

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      word_t byte_mask;
      word_t fault_events;
      word_t flag_sets;
      word_t flag_clears;
      logic wr_fire;
      logic rd_fire;
      logic both_done;
      logic [ADDR_W-1:0] rd_ofs;
      byte_mask = '0;
      fault_events = '0;
      flag_sets = '0;
      flag_clears = '0;
      wr_fire = 1'b0;
      rd_fire = 1'b0;
      both_done = 1'b0;
      rd_ofs = '0;
      nxt = cur;

      for (int i = 0; i < 4; i++) begin
         byte_mask[i*8 +: 8] = {8{s_wstrb[i]}};
      end

      // write channel: address and data taken together, one response each
      wr_fire = cur.aw_ready && cur.w_ready && s_awvalid && s_wvalid;
      nxt.aw_ready = 1'b0;
      nxt.w_ready = 1'b0;
      if (!cur.aw_ready && s_awvalid && s_wvalid && !cur.b_valid) begin
         nxt.aw_ready = 1'b1;
         nxt.w_ready = 1'b1;
      end
      if (cur.b_valid && s_bready) begin
         nxt.b_valid = 1'b0;
      end
      if (wr_fire) begin
         nxt.b_valid = 1'b1;
         nxt.b_resp = `RESP_OKAY;
         case ({s_awaddr[ADDR_W-1:2], 2'b00})
            `OFS_SLAVE_PORT_CONTROL: begin
               nxt.slave_port_control = ((cur.slave_port_control & ~byte_mask) | (s_wdata & byte_mask))
                  & `MASK_SLAVE_PORT_CONTROL;
            end
            `OFS_ERROR_FLAGS: begin
               flag_clears = s_wdata & byte_mask;
            end
            `OFS_ERROR_FLAG_ENABLES: begin
               nxt.error_flag_enables = ((cur.error_flag_enables & ~byte_mask) | (s_wdata & byte_mask))
                  & `MASK_ERROR_FLAGS;
            end
            `OFS_MASTER_FAULT_IRQ_ENABLE: begin
               nxt.master_fault_irq_enable = ((cur.master_fault_irq_enable & ~byte_mask)
                  | (s_wdata & byte_mask)) & `MASK_MASTER_FAULT_IRQ_ENABLE;
            end
            `OFS_BUILD_CONFIGURATION: begin
               // read-only: write accepted and ignored
               nxt.b_resp = `RESP_OKAY;
            end
            default: begin
               nxt.b_resp = `RESP_SLVERR;
            end
         endcase
      end

      // read channel
      rd_fire = cur.ar_ready && s_arvalid;
      nxt.ar_ready = 1'b0;
      if (!cur.ar_ready && s_arvalid && !cur.r_valid) begin
         nxt.ar_ready = 1'b1;
      end
      if (cur.r_valid && s_rready) begin
         nxt.r_valid = 1'b0;
      end
      if (rd_fire) begin
         rd_ofs = {s_araddr[ADDR_W-1:2], 2'b00};
         nxt.r_valid = 1'b1;
         nxt.r_resp = `RESP_OKAY;
         case (rd_ofs)
            `OFS_SLAVE_PORT_CONTROL: nxt.r_data = cur.slave_port_control;
            `OFS_ERROR_FLAGS: nxt.r_data = cur.error_flags;
            `OFS_ERROR_FLAG_ENABLES: nxt.r_data = cur.error_flag_enables;
            `OFS_MASTER_FAULT_IRQ_ENABLE: nxt.r_data = cur.master_fault_irq_enable;
            `OFS_BUILD_CONFIGURATION: nxt.r_data = build_word;
            default: begin
               nxt.r_data = '0;
               nxt.r_resp = `RESP_SLVERR;
            end
         endcase
      end

      // error capture; completion flags on the rising edge of both-done so a clear sticks
      both_done = master_write_cmds_done && master_read_cmds_done;
      nxt.both_done_seen = both_done;
      fault_events[`BIT_MASTER_COMPLETION_FLAG] = both_done && !cur.both_done_seen;
      fault_events[`BIT_MASTER_READ_ID_FAULT] = master_read_id_fault;
      fault_events[`BIT_MASTER_WRITE_ID_FAULT] = master_write_id_fault;
      fault_events[`BIT_MASTER_WRITE_RESP_FAULT] = master_write_resp_fault;
      fault_events[`BIT_MASTER_READ_RESP_FAULT] = master_read_resp_fault;
      fault_events[`BIT_MASTER_READ_LENGTH_FAULT] = master_read_length_fault;
      fault_events[`BIT_SLAVE_STROBE_LANE_FAULT] = slave_strobe_lane_fault;
      fault_events[`BIT_SLAVE_WRITE_LENGTH_FAULT] = slave_write_length_fault;
      flag_sets = fault_events & cur.error_flag_enables & `MASK_ERROR_FLAGS;
      // set wins over a clear in the same cycle so no event is lost
      nxt.error_flags = ((cur.error_flags & ~flag_clears) | flag_sets) & `MASK_ERROR_FLAGS;

      // outputs follow the new flags so they track the register without extra lag
      nxt.fault_out = (nxt.slave_port_control[`BIT_SLAVE_FAULT_OUTPUT_ENABLE]
            && |(nxt.error_flags & `MASK_SLAVE_FAULTS))
         || (nxt.master_fault_irq_enable[`BIT_MASTER_FAULT_OUTPUT_ENABLE]
            && |(nxt.error_flags & `MASK_MASTER_FAULTS));
      nxt.completion_irq = nxt.error_flags[`BIT_MASTER_COMPLETION_FLAG];
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
         cur.slave_port_control <= `RST_SLAVE_PORT_CONTROL;
         cur.error_flags <= `RST_ERROR_FLAGS;
         cur.error_flag_enables <= `RST_ERROR_FLAG_ENABLES;
         cur.master_fault_irq_enable <= `RST_MASTER_FAULT_IRQ_ENABLE;
      end else begin
         cur <= nxt;
      end
   end

   // ****************************************
   // outputs, each straight from the state register
   // ****************************************
   assign s_awready = cur.aw_ready;
   assign s_wready = cur.w_ready;
   assign s_bresp = cur.b_resp;
   assign s_bvalid = cur.b_valid;
   assign s_arready = cur.ar_ready;
   assign s_rdata = cur.r_data;
   assign s_rresp = cur.r_resp;
   assign s_rvalid = cur.r_valid;
   // the slave port logic honours these; this block only holds the settings
   assign block_reads_while_writes_pending = cur.slave_port_control[`BIT_BLOCK_READS_WHILE_WRITES_PENDING];
   assign exclusive_access_off = cur.slave_port_control[`BIT_EXCLUSIVE_ACCESS_OFF];
   assign in_order_write_responses = cur.slave_port_control[`BIT_IN_ORDER_WRITE_RESPONSES];
   assign in_order_read_responses = cur.slave_port_control[`BIT_IN_ORDER_READ_RESPONSES];
   assign err_out = cur.fault_out;
   assign irq_out = cur.completion_irq;

endmodule

// File: tb/slave_ctrl_error_regs_props.sv
// port assertions for the control and error register group
`timescale 1ns/10ps
module slave_ctrl_error_regs_props #(
   parameter int ADDR_W = 6,
   parameter logic [2:0] MASTER_WIDTH_CODE = 3'h0,
   parameter logic [2:0] SLAVE_WIDTH_CODE = 3'h0,
   parameter logic ADVANCED_MODE = 1'b1
) (
   input wire logic core_clk, // clock
   input wire logic nrst, // reset, active low
   input wire logic [ADDR_W-1:0] s_awaddr, // write address
   input wire slave_ctrl_error_regs_pkg::word_t s_wdata, // write data
   input wire logic [3:0] s_wstrb, // byte enables
   input wire logic s_awready, // write taken
   input wire logic s_wready, // write data taken
   input wire logic s_bvalid, // write answer valid
   input wire slave_ctrl_error_regs_pkg::resp_t s_bresp, // write answer
   input wire logic [ADDR_W-1:0] s_araddr, // read address
   input wire logic s_arready, // read taken
   input wire logic s_rvalid, // read answer valid
   input wire slave_ctrl_error_regs_pkg::word_t s_rdata, // read data
   input wire logic master_write_cmds_done, // write engine done
   input wire logic master_read_cmds_done, // read engine done
   input wire logic block_reads_while_writes_pending, // control 19
   input wire logic exclusive_access_off, // control 18
   input wire logic in_order_write_responses, // control 17
   input wire logic in_order_read_responses, // control 16
   input wire logic err_out, // error level
   input wire logic irq_out // completion level
);
   import slave_ctrl_error_regs_pkg::*;
   // ****************************************
   // helpers and properties
   // ****************************************
   logic [3:0] ctrl;
   logic clr31;
   assign ctrl = {block_reads_while_writes_pending, exclusive_access_off, in_order_write_responses,
      in_order_read_responses};
   assign clr31 = s_awready && s_awaddr[5:2] == 4'h2 && s_wstrb[3] && s_wdata[31];
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   sequence ctrl_write;
      s_awready && s_awaddr[5:2] == 4'h1 && s_wstrb[2];
   endsequence
   sequence answer_up;
      !s_awready && s_bvalid;
   endsequence
   a_ctrl_load: assert property (ctrl_write |=> ctrl == $past(s_wdata[19:16]))
      else $error("control outputs differ from written bits");
   a_ctrl_only_written: assert property ($changed(ctrl) |-> $past(s_awready))
      else $error("control outputs moved without a write");
   a_write_walk: assert property (s_awready |=> answer_up)
      else $error("write answer not raised after acceptance");
   a_unmapped_slverr: assert property (s_awready && s_awaddr[5:2] == 4'h0 |=> s_bvalid && s_bresp == 2'h2)
      else $error("unmapped write not answered with slave error");
   a_cfg_readout: assert property (s_arready && s_araddr[5:2] == 4'h5 |=> s_rvalid && s_rdata ==
      {1'b0, MASTER_WIDTH_CODE, SLAVE_WIDTH_CODE, ADVANCED_MODE, !ADVANCED_MODE, 23'h0})
      else $error("build configuration readout wrong");
   a_irq_cause: assert property ($rose(irq_out) |-> $past(master_write_cmds_done && master_read_cmds_done))
      else $error("completion interrupt without both engines done");
   a_irq_sticks: assert property (irq_out && !clr31 |=> irq_out)
      else $error("completion interrupt dropped without a clear");
   a_err_level: assert property (err_out && !s_awready && !$past(s_awready) |=> err_out)
      else $error("error output dropped without a register write");
   a_wready_pair: assert property (s_wready == s_awready)
      else $error("write data ready not paired with write address ready");
endmodule

bind slave_ctrl_error_regs slave_ctrl_error_regs_props #(.ADDR_W(ADDR_W), .MASTER_WIDTH_CODE(MASTER_WIDTH_CODE),
   .SLAVE_WIDTH_CODE(SLAVE_WIDTH_CODE), .ADVANCED_MODE(ADVANCED_MODE)) i_props (.*);

// File: tb/reg_host_answer_model.sv
// host-side answer model: takes write and read answers promptly or late
`timescale 1ns/10ps
module reg_host_answer_model (
   input wire logic core_clk, // clock
   input wire logic nrst, // reset, active low
   input wire logic slow, // late mode
   input wire logic s_bvalid, // write answer valid
   input wire logic s_rvalid, // read answer valid
   output logic s_bready, // write answer taken
   output logic s_rready // read answer taken
);
   // ****************************************
   // wait counters
   // ****************************************
   logic [1:0] bwait;
   logic [1:0] rwait;
   // late mode keeps answers standing three cycles, so held outputs get exercised
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bwait <= 2'h0;
         rwait <= 2'h0;
      end else begin
         bwait <= (s_bvalid && !s_bready) ? bwait + 2'h1 : 2'h0;
         rwait <= (s_rvalid && !s_rready) ? rwait + 2'h1 : 2'h0;
      end
   end
   assign s_bready = s_bvalid && (!slow || bwait == 2'h3);
   assign s_rready = s_rvalid && (!slow || rwait == 2'h3);
endmodule

// File: tb/slave_ctrl_error_regs_tb.sv
// self-checking bench for the control and error register group
`timescale 1ns/10ps
module slave_ctrl_error_regs_tb;
   import slave_ctrl_error_regs_pkg::*;
   // ****************************************
   // signals, table, tasks
   // ****************************************
   localparam logic [2:0] MASTER_WIDTH_CODE = 3'h4;
   localparam logic [2:0] SLAVE_WIDTH_CODE = 3'h1;
   localparam word_t CFG = {1'b0, MASTER_WIDTH_CODE, SLAVE_WIDTH_CODE, 2'h1, 23'h0};
   typedef struct {logic wr; logic [5:0] a; word_t d; word_t exp; resp_t rsp;} row_t;
   logic core_clk, nrst, s_awvalid, s_wvalid, s_arvalid, slow, s_awready, s_wready, s_bvalid, s_bready;
   logic s_arready, s_rvalid, s_rready, err_out, irq_out, master_write_cmds_done, master_read_cmds_done;
   logic block_reads_while_writes_pending, exclusive_access_off, in_order_write_responses, in_order_read_responses;
   logic [5:0] s_awaddr, s_araddr;
   logic [3:0] s_wstrb;
   logic [6:0] evt;
   word_t s_wdata, s_rdata, rd_d;
   resp_t s_bresp, s_rresp, rs;
   int failures, n_checks;
   row_t rows[12] = '{'{1'b0, 6'h04, '0, '0, '0}, '{1'b0, 6'h08, '0, '0, '0}, '{1'b0, 6'h0c, '0, 32'h8000_0000, '0},
      '{1'b0, 6'h10, '0, '0, '0}, '{1'b0, 6'h14, '0, CFG, '0}, '{1'b1, 6'h04, '1, 32'h000f_8000, '0},
      '{1'b1, 6'h0c, '1, 32'h801f_0003, '0}, '{1'b1, 6'h10, '1, 32'h0000_8000, '0}, '{1'b1, 6'h14, '1, CFG, '0},
      '{1'b1, 6'h00, '1, '0, 2'h2}, '{1'b1, 6'h3c, '1, '0, 2'h2}, '{1'b1, 6'h08, '1, '0, '0}};
   slave_ctrl_error_regs #(.MASTER_WIDTH_CODE(MASTER_WIDTH_CODE), .SLAVE_WIDTH_CODE(SLAVE_WIDTH_CODE),
      .ADVANCED_MODE(1'b0)) i_dut (.*, .master_read_id_fault(evt[6]), .master_write_id_fault(evt[5]),
      .master_write_resp_fault(evt[4]), .master_read_resp_fault(evt[3]), .master_read_length_fault(evt[2]),
      .slave_strobe_lane_fault(evt[1]), .slave_write_length_fault(evt[0]));
   reg_host_answer_model i_host (.*);
   always #5 core_clk = ~core_clk;
   function automatic word_t bits(input logic [6:0] m);
      return {11'h0, m[6:2], 14'h0, m[1:0]};
   endfunction
   task automatic chk_w(input string nm, input word_t exp, input word_t got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_b(input string nm, input logic exp, input logic got);
      chk_w(nm, {31'h0, exp}, {31'h0, got});
   endtask
   task automatic wr(input logic [5:0] a, input word_t d, output resp_t r);
      @(negedge core_clk);
      {s_awaddr, s_wdata, s_awvalid, s_wvalid} = {a, d, 2'h3};
      for (int k = 0; k < 20 && !s_awready; k++) @(negedge core_clk);
      // a handshake that never comes counts against the run
      if (!s_awready) failures++;
      @(negedge core_clk);
      {s_awvalid, s_wvalid} = 2'h0;
      for (int k = 0; k < 20 && !(s_bvalid && s_bready); k++) @(negedge core_clk);
      if (!(s_bvalid && s_bready)) failures++;
      r = s_bresp;
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [5:0] a, output word_t d, output resp_t r);
      @(negedge core_clk);
      {s_araddr, s_arvalid} = {a, 1'b1};
      for (int k = 0; k < 20 && !s_arready; k++) @(negedge core_clk);
      if (!s_arready) failures++;
      @(negedge core_clk);
      s_arvalid = 1'b0;
      for (int k = 0; k < 20 && !(s_rvalid && s_rready); k++) @(negedge core_clk);
      if (!(s_rvalid && s_rready)) failures++;
      {d, r} = {s_rdata, s_rresp};
      @(negedge core_clk);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(negedge core_clk);
      evt = m;
      @(negedge core_clk);
      evt = 7'h0;
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      end_sim();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {core_clk, nrst, s_awvalid, s_wvalid, s_arvalid, slow, master_write_cmds_done, master_read_cmds_done} = '0;
      {s_awaddr, s_araddr, s_wdata, s_wstrb, evt, failures, n_checks} = {44'h0, 4'hf, 7'h0, 64'h0};
      repeat (12) @(negedge core_clk);
      nrst = 1'b1;
      foreach (rows[i]) begin
         slow = i[0];
         if (rows[i].wr) wr(rows[i].a, rows[i].d, rs);
         if (rows[i].wr) chk_w("bresp", {30'h0, rows[i].rsp}, {30'h0, rs});
         rd(rows[i].a, rd_d, rs);
         chk_w("rdata", rows[i].exp, rd_d);
         chk_w("rresp", {30'h0, rows[i].rsp}, {30'h0, rs});
      end
      chk_w("controls", 32'hf, {28'h0, block_reads_while_writes_pending, exclusive_access_off,
         in_order_write_responses, in_order_read_responses});
      // only the top byte lane enabled: bit 31 cleared, lower enables kept
      s_wstrb = 4'h8;
      wr(6'h0c, 32'h0, rs);
      s_wstrb = 4'hf;
      rd(6'h0c, rd_d, rs);
      chk_w("enables", 32'h001f_0003, rd_d);
      // last pass leaves every enable off, so a fault must then leave no trace
      for (int b = 0; b < 8; b++) begin
         wr(6'h0c, bits(7'h1 << b), rs);
         pulse(7'h7f);
         rd(6'h08, rd_d, rs);
         chk_w("flags", bits(7'h1 << b), rd_d);
         chk_b("err_out", b < 7, err_out);
         wr(6'h08, 32'hffff_ffff, rs);
         chk_b("err_out", 1'b0, err_out);
      end
      wr(6'h0c, 32'hffff_ffff, rs);
      wr(6'h10, 32'h0, rs);
      pulse(7'h7c);
      chk_b("err_out", 1'b0, err_out);
      wr(6'h10, 32'h0000_8000, rs);
      chk_b("err_out", 1'b1, err_out);
      wr(6'h04, 32'h0, rs);
      pulse(7'h03);
      wr(6'h10, 32'h0, rs);
      chk_b("err_out", 1'b0, err_out);
      wr(6'h04, 32'h0000_8000, rs);
      chk_b("err_out", 1'b1, err_out);
      wr(6'h08, 32'h0000_0002, rs);
      rd(6'h08, rd_d, rs);
      chk_w("flags", 32'h001f_0001, rd_d);
      chk_b("err_out", 1'b1, err_out);
      master_write_cmds_done = 1'b1;
      pulse(7'h0);
      master_read_cmds_done = 1'b1;
      pulse(7'h0);
      chk_b("irq_out", 1'b1, irq_out);
      wr(6'h08, 32'h8000_0000, rs);
      chk_b("irq_out", 1'b0, irq_out);
      {master_write_cmds_done, master_read_cmds_done} = 2'h0;
      wr(6'h0c, 32'h001f_0003, rs);
      {master_write_cmds_done, master_read_cmds_done} = 2'h3;
      pulse(7'h0);
      rd(6'h08, rd_d, rs);
      chk_w("flags", 32'h001f_0001, rd_d);
      nrst = 1'b0;
      pulse(7'h0);
      nrst = 1'b1;
      rd(6'h0c, rd_d, rs);
      chk_w("enables", 32'h8000_0000, rd_d);
      // both engines still done and the enable back at one, so completion is flagged again
      chk_b("irq_out", 1'b1, irq_out);
      chk_b("err_out", 1'b0, err_out);
      end_sim();
   end
endmodule
